//--- src/mbd_datapath.v
// bit-op, divide and data-segment datapath with an APB register face
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mbd_datapath
(
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         BUSY
);
`include "mbd_defs.vh"
  reg  [31:0] ctrl_reg;
  reg  [31:0] src1_reg;
  reg  [31:0] src2_reg;
  reg  [31:0] dst_reg;
  reg  [31:0] flags_reg;
  reg  [31:0] result_reg;
  reg  [31:0] sp_reg;
  reg         div_wait_reg;
  reg         div_mod_reg;
  reg  [7:0]  dseg [0:`MBD_DSEG_BYTES-1];

  wire [3:0]  sub    = ctrl_reg[`MBD_CTRL_SUB_LSB+3:`MBD_CTRL_SUB_LSB];
  wire [5:0]  sub6   = ctrl_reg[`MBD_CTRL_SUB_LSB+5:`MBD_CTRL_SUB_LSB];
  wire [7:0]  opc    = ctrl_reg[`MBD_CTRL_OPC_LSB+7:`MBD_CTRL_OPC_LSB];
  wire        ver3   = ctrl_reg[`MBD_CTRL_VER3];
  wire [1:0]  sz     = ctrl_reg[`MBD_CTRL_SZ_LSB+1:`MBD_CTRL_SZ_LSB];
  wire        div_done;
  wire [31:0] quo;
  wire [31:0] rem;

  wire        setup  = PSEL && !PENABLE;
  wire        wr_acc = PSEL && PENABLE && PWRITE;
  wire        go     = wr_acc && PADDR == `MBD_ADDR_CTRL && PWDATA[`MBD_CTRL_GO] && !BUSY;
  // divider starts on the go edge itself so the whole divide fits 33 cycles
  wire        div_go = go && PWDATA[`MBD_CTRL_VER3] &&
                       (PWDATA[23:16] == 8'hc0 || PWDATA[23:16] == 8'he0 ||
                        PWDATA[23:16] == 8'hff) &&
                       (PWDATA[11:8] == `MBD_SUB_DIV || PWDATA[11:8] == `MBD_SUB_MOD);

  // execution combinational terms
  wire [4:0]  lo     = src2_reg[4:0];
  wire [5:0]  fsize  = {1'b0, src2_reg[9:5]} + 6'd1;
  wire [6:0]  fend   = {2'b00, lo} + {1'b0, fsize};
  wire [31:0] fmask  = (fsize == 6'd32) ? 32'hffffffff : ((32'h00000001 << fsize) - 32'h00000001);
  wire [31:0] ins_v  = (dst_reg & ~(fmask << lo)) | ((src1_reg & fmask) << lo);
  wire        rmw_fl = opc == 8'hf4 || opc == 8'hf9;
  wire [31:0] bdst   = rmw_fl ? flags_reg : dst_reg;
  wire [31:0] bsel   = 32'h00000001 << lo;
  wire        xsrc_f = opc == 8'hf0 || opc == 8'hfe;
  wire        xbit   = xsrc_f ? flags_reg[lo] : src1_reg[lo];
  wire        is_mem = opc == 8'h10 || opc == 8'h34 || opc == 8'h3a || opc == 8'h3c;
  wire        is_st  = opc == 8'h00 || opc == 8'h30 || opc == 8'h38;
  wire        sp_frm = opc == 8'h34 || opc == 8'h3a || opc == 8'h30 || opc == 8'h38;
  wire [31:0] mbase  = sp_frm ? sp_reg : src1_reg;
  wire [31:0] maddr  = mbase + (src2_reg << sz);
  wire [`MBD_DSEG_AW-1:0] a8  = maddr[`MBD_DSEG_AW-1:0];
  wire [`MBD_DSEG_AW-1:0] a16 = {maddr[`MBD_DSEG_AW-1:1], 1'b0};
  wire [`MBD_DSEG_AW-1:0] a32 = {maddr[`MBD_DSEG_AW-1:2], 2'b00};
  wire [31:0] sval32 = maddr[0] ? ((dst_reg & 32'h000000ff) << {maddr[1:0], 3'b000})
                     : maddr[1] ? ((dst_reg & 32'h0000ffff) << 16) : dst_reg;
  wire [15:0] sval16 = maddr[0] ? {dst_reg[7:0], 8'h00} : dst_reg[15:0];
  wire [31:0] caps   = `MBD_DSEG_BYTES << 1;

  reg  [31:0] logic_v;
  always @*
  begin
    case (sub)
      `MBD_SUB_AND: logic_v = src1_reg & src2_reg;
      `MBD_SUB_OR:  logic_v = src1_reg | src2_reg;
      default:      logic_v = src1_reg ^ src2_reg;
    endcase
  end

  mbd_divider u_div
  (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .start     (div_go),
    .dividend  (src1_reg),
    .divisor   (src2_reg),
    .done      (div_done),
    .quotient  (quo),
    .remainder (rem)
  );

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ctrl_reg      <= 32'h00000000;
      src1_reg      <= 32'h00000000;
      src2_reg      <= 32'h00000000;
      dst_reg       <= 32'h00000000;
      flags_reg     <= `MBD_FLAGS_RESET;
      result_reg    <= 32'h00000000;
      sp_reg        <= 32'h00000000;
      div_wait_reg  <= 1'b0;
      div_mod_reg   <= 1'b0;
      BUSY          <= 1'b0;
      PRDATA        <= 32'h00000000;
      PREADY        <= 1'b0;
      PSLVERR       <= 1'b0;
    end
    else
    begin
      PREADY        <= setup;
      PSLVERR       <= 1'b0;
      if (setup)
      begin
        if (PADDR == `MBD_ADDR_CTRL)
          PRDATA <= ctrl_reg;
        else if (PADDR == `MBD_ADDR_STATUS)
          PRDATA <= {31'h00000000, BUSY};
        else if (PADDR == `MBD_ADDR_SRC1)
          PRDATA <= src1_reg;
        else if (PADDR == `MBD_ADDR_SRC2)
          PRDATA <= src2_reg;
        else if (PADDR == `MBD_ADDR_DST)
          PRDATA <= dst_reg;
        else if (PADDR == `MBD_ADDR_FLAGS)
          PRDATA <= flags_reg;
        else if (PADDR == `MBD_ADDR_RESULT)
          PRDATA <= result_reg;
        else if (PADDR == `MBD_ADDR_SP)
          PRDATA <= sp_reg;
        else if (PADDR == `MBD_ADDR_CAPS)
          PRDATA <= caps & (32'h000000ff << `MBD_CAPS_SIZE_LSB);
        else
        begin
          PRDATA  <= 32'h00000000;
          PSLVERR <= 1'b1;
        end
      end
      // operand writes are ignored while a divide runs so its inputs stay put
      if (wr_acc && !BUSY)
      begin
        if (PADDR == `MBD_ADDR_SRC1)
          src1_reg <= PWDATA;
        else if (PADDR == `MBD_ADDR_SRC2)
          src2_reg <= PWDATA;
        else if (PADDR == `MBD_ADDR_DST)
          dst_reg <= PWDATA;
        else if (PADDR == `MBD_ADDR_FLAGS)
          flags_reg <= PWDATA;
        else if (PADDR == `MBD_ADDR_SP)
          sp_reg <= PWDATA & (`MBD_DSEG_BYTES - 4);
        else if (PADDR == `MBD_ADDR_CTRL)
          ctrl_reg <= PWDATA & ~32'h00000001;
      end
      if (go)
      begin
        // single-cycle execute on the edge after the go write
        ctrl_reg <= PWDATA & ~32'h00000001;
      end
      if (BUSY && !div_wait_reg)
      begin
        BUSY <= 1'b0;
        if (is_mem && (sp_frm ? sub == `MBD_SUB_LD_SP : sub == `MBD_SUB_LD))
        begin
          // little-endian assembly, aligned fetch
          if (sz == 2'd2)
            result_reg <= {dseg[a32+3], dseg[a32+2], dseg[a32+1], dseg[a32]};
          else if (sz == 2'd1)
            result_reg <= {16'h0000, dseg[a16+1], dseg[a16]};
          else
            result_reg <= {24'h000000, dseg[a8]};
        end
        else if (is_st && (sp_frm ? sub == `MBD_SUB_ST_SP : sub == `MBD_SUB_ST))
        begin
          if (sz == 2'd2)
          begin
            dseg[a32]   <= sval32[7:0];
            dseg[a32+1] <= sval32[15:8];
            dseg[a32+2] <= sval32[23:16];
            dseg[a32+3] <= sval32[31:24];
          end
          else if (sz == 2'd1)
          begin
            dseg[a16]   <= sval16[7:0];
            dseg[a16+1] <= sval16[15:8];
          end
          else
            dseg[a8] <= dst_reg[7:0];
        end
        else if ((opc == 8'hf2 || opc == 8'hfa) && sub == `MBD_SUB_SETP)
          flags_reg[lo] <= src1_reg[0];
        else if (opc == 8'hf4 && sub6 >= `MBD_SUBF4_BSET && sub6 <= `MBD_SUBF4_BTGL)
        begin
          if (sub6 == `MBD_SUBF4_BSET)
            flags_reg <= flags_reg | bsel;
          else if (sub6 == `MBD_SUBF4_BCLR)
            flags_reg <= flags_reg & ~bsel;
          else
            flags_reg <= flags_reg ^ bsel;
        end
        else if ((opc == 8'hf0 || opc == 8'hfd || opc == 8'hf9) &&
                 (sub == `MBD_SUB_BSET || sub == `MBD_SUB_BCLR || sub == `MBD_SUB_BTGL))
        begin
          if (opc == 8'hf9)
            flags_reg <= (sub == `MBD_SUB_BSET) ? (bdst | bsel) :
                         (sub == `MBD_SUB_BCLR) ? (bdst & ~bsel) : (bdst ^ bsel);
          else
            dst_reg <= (sub == `MBD_SUB_BSET) ? (bdst | bsel) :
                       (sub == `MBD_SUB_BCLR) ? (bdst & ~bsel) : (bdst ^ bsel);
        end
        else if (((opc == 8'hc0 || opc == 8'hff) && sub == `MBD_SUB_XBIT) ||
                 (xsrc_f && sub == `MBD_SUB_XBIT_F))
        begin
          if (ver3)
          begin
            dst_reg                <= {31'h00000000, xbit};
            flags_reg[`MBD_FLAG_S] <= 1'b0;
            flags_reg[`MBD_FLAG_Z] <= ~xbit;
          end
          else
            dst_reg <= {dst_reg[31:1], xbit};
        end
        else if ((opc == 8'hc0 || opc == 8'he0) && sub == `MBD_SUB_INS)
        begin
          if (fend <= 7'd32)
            dst_reg <= ins_v;
        end
        else if (sub == `MBD_SUB_AND || sub == `MBD_SUB_OR || sub == `MBD_SUB_XOR)
        begin
          dst_reg <= logic_v;
          if (ver3)
          begin
            flags_reg[`MBD_FLAG_C] <= 1'b0;
            flags_reg[`MBD_FLAG_O] <= 1'b0;
            flags_reg[`MBD_FLAG_S] <= logic_v[31];
            flags_reg[`MBD_FLAG_Z] <= logic_v == 32'h00000000;
          end
        end
      end
      if (go)
      begin
        BUSY <= 1'b1;
        if (div_go)
        begin
          div_wait_reg  <= 1'b1;
          div_mod_reg   <= PWDATA[11:8] == `MBD_SUB_MOD;
        end
      end
      // 32 steps after the go edge, result on the next: busy for 33 cycles
      if (div_done)
      begin
        div_wait_reg <= 1'b0;
        BUSY         <= 1'b0;
        dst_reg      <= div_mod_reg ? rem : quo;
      end
    end
  end
endmodule

//--- src/mbd_defs.vh
// constants for the bit-operation, divide and data-segment datapath
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
`define MBD_ADDR_CTRL      12'h000
`define MBD_ADDR_STATUS    12'h004
`define MBD_ADDR_SRC1      12'h008
`define MBD_ADDR_SRC2      12'h00c
`define MBD_ADDR_DST       12'h010
`define MBD_ADDR_FLAGS     12'h014
`define MBD_ADDR_RESULT    12'h018
`define MBD_ADDR_SP        12'h01c
`define MBD_ADDR_CAPS      12'h020
`define MBD_CTRL_GO        0
`define MBD_CTRL_SUB_LSB   8
`define MBD_CTRL_OPC_LSB   16
`define MBD_CTRL_VER3      24
`define MBD_CTRL_SZ_LSB    25
`define MBD_SUB_ST         4'h0
`define MBD_SUB_ST_SP      4'h1
`define MBD_SUB_AND        4'h4
`define MBD_SUB_OR         4'h5
`define MBD_SUB_XOR        4'h6
`define MBD_SUB_INS        4'hb
`define MBD_SUB_XBIT       4'h8
`define MBD_SUB_XBIT_F     4'hc
`define MBD_SUB_BSET       4'h9
`define MBD_SUB_BCLR       4'ha
`define MBD_SUB_BTGL       4'hb
`define MBD_SUB_DIV        4'hc
`define MBD_SUB_MOD        4'hd
`define MBD_SUB_LD         4'h8
`define MBD_SUB_LD_SP      4'h0
`define MBD_SUB_SETP       4'h8
`define MBD_SUBF4_BSET     6'h31
`define MBD_SUBF4_BCLR     6'h32
`define MBD_SUBF4_BTGL     6'h33
`define MBD_FLAG_C         8
`define MBD_FLAG_O         9
`define MBD_FLAG_S         10
`define MBD_FLAG_Z         11
`define MBD_DSEG_BYTES     1024
`define MBD_DSEG_AW        10
`define MBD_CAPS_SIZE_LSB  9
`define MBD_DIV_STEPS      6'd32
`define MBD_FLAGS_RESET    32'h00000000
`endif

//--- src/mbd_divider.v
// unsigned 32-bit restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module mbd_divider
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [31:0] dividend,
  input  wire [31:0] divisor,
  output reg         done,
  output reg  [31:0] quotient,
  output reg  [31:0] remainder
);
`include "mbd_defs.vh"
  reg  [5:0]  cnt_reg;
  reg         busy_reg;
  reg  [31:0] d_reg;
  wire [32:0] trial;

  assign trial = {remainder, quotient[31]} - {1'b0, d_reg};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg   <= 6'd0;
      busy_reg  <= 1'b0;
      d_reg     <= 32'h00000000;
      done      <= 1'b0;
      quotient  <= 32'h00000000;
      remainder <= 32'h00000000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy_reg  <= 1'b1;
        cnt_reg   <= `MBD_DIV_STEPS;
        d_reg     <= divisor;
        quotient  <= dividend;
        remainder <= 32'h00000000;
      end
      else if (busy_reg)
      begin
        // zero divisor falls out naturally: every trial succeeds, giving
        // all-ones quotient and the dividend as remainder
        if (!trial[32])
        begin
          remainder <= trial[31:0];
          quotient  <= {quotient[30:0], 1'b1};
        end
        else
        begin
          remainder <= {remainder[30:0], quotient[31]};
          quotient  <= {quotient[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'd1;
        if (cnt_reg == 6'd1)
        begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end
endmodule

//--- tb/mbd_checker.sv
// port-level assertions for the bit-op, divide and data-segment datapath
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mbd_checker
(
  input wire        MCLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE && PREADY;
  wire rd  = acc && !PWRITE;
  wire go  = acc && PWRITE && PADDR == `MBD_ADDR_CTRL && PWDATA[0] && !BUSY;
  // divide is subop c or d under the c0 form
  wire dq  = PWDATA[23:16] == 8'hc0 && PWDATA[13:9] == 5'b00110;
  wire dv  = go && PWDATA[24] && dq;
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing in access phase");
  a_ready_one_pulse: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready outside access or longer than one cycle");
  a_err_unmapped: assert property (acc && PADDR > `MBD_ADDR_CAPS |-> PSLVERR)
    else $error("unmapped access without error");
  a_err_mapped: assert property (acc && PADDR <= `MBD_ADDR_CAPS &&
    PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("mapped access flagged as error");
  a_caps_size: assert property (rd && PADDR == `MBD_ADDR_CAPS |->
    PRDATA == 32'h0000_0800)
    else $error("capability word wrong");
  a_sp_aligned: assert property (rd && PADDR == `MBD_ADDR_SP |->
    PRDATA[1:0] == 2'b00 && PRDATA[31:10] == 22'h0)
    else $error("stack pointer not masked");
  a_single_cycle: assert property (go && !dq |-> ##[1:3] !BUSY)
    else $error("single-cycle op stayed busy");
  a_div_holds: assert property (dv |-> ##1 BUSY [*8] ##1 BUSY [*8] ##1 BUSY [*8]
    ##1 BUSY [*5] ##[1:5] !BUSY)
    else $error("divide busy window wrong");
  a_busy_cause: assert property ($rose(BUSY) |-> $past(go) || $past(go, 2))
    else $error("busy rose without a go");
  c_div: cover property (dv);
  c_err: cover property (acc && PSLVERR);
  c_single: cover property (go && !dq ##3 !BUSY);
endmodule
bind mbd_datapath mbd_checker chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .BUSY(BUSY));

//--- tb/mcu_bitop_divide_data_space_test.sv
// self-checking bench for the bit-op, divide and data-segment datapath
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mcu_bitop_divide_data_space_test;
  localparam [18*16-1:0] OPS = {16'hc004, 16'hc005, 16'hc006, 16'hc00b, 16'hc008, 16'hf00c,
    16'hf009, 16'hf00a, 16'hf00b, 16'hf431, 16'hf432, 16'hf433, 16'hf909, 16'hf90a, 16'hf90b,
    16'hc00c, 16'hc00d, 16'hf208};
  reg         mclk;
  reg         rst_n;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        busy;
  integer     n_errors;
  integer     check_count;
  integer     seed;
  integer     i;
  integer     k;
  reg  [31:0] s1;
  reg  [31:0] s2;
  reg  [31:0] d;
  reg  [31:0] f;
  reg  [31:0] q;
  reg  [31:0] c;
  reg  [31:0] b0;
  reg  [31:0] a;
  reg  [31:0] v;
  reg  [15:0] key;
  reg  [1:0]  z;
  reg         err;
  reg  [63:0] e;
  reg  [7:0]  mem [0:1023];

  mbd_datapath uut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUSY(busy));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // one idle edge first so psel is never assigned twice in one time step
  task apb(input w, input [11:0] ad, input [31:0] wd);
    integer n;
  begin
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge mclk);
    end
    if (n == 20)
      n_errors = n_errors + 1;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task wait_idle;
    integer n;
  begin
    n = 0;
    repeat (2) @(posedge mclk);
    while (busy !== 1'b0 && n < 100)
    begin
      n = n + 1;
      @(posedge mclk);
    end
  end
  endtask

  task run(input [31:0] cc);
  begin
    apb(1'b1, `MBD_ADDR_CTRL, cc);
    wait_idle;
  end
  endtask

  task setr(input [31:0] x1, input [31:0] x2, input [31:0] xd, input [31:0] xf);
  begin
    apb(1'b1, `MBD_ADDR_SRC1, x1);
    apb(1'b1, `MBD_ADDR_SRC2, x2);
    apb(1'b1, `MBD_ADDR_DST, xd);
    apb(1'b1, `MBD_ADDR_FLAGS, xf);
  end
  endtask

  function [31:0] cw(input [7:0] o, input [5:0] s, input [1:0] sz);
    cw = {5'h0, sz, 1'b0, o, 2'b00, s, 8'h01};
  endfunction

  function [63:0] model(input [31:0] cc);
    reg [31:0] x;
    reg [31:0] g;
    reg [31:0] bm;
    reg [63:0] m;
    reg        bt;
    integer    lo;
    integer    sz;
  begin
    x = d;
    g = f;
    bm = 32'h1 << s2[4:0];
    lo = s2[4:0];
    sz = s2[9:5] + 1;
    m = (64'h1 << sz) - 64'h1;
    bt = ((cc[23:16] == 8'hf0) ? f : s1) >> s2[4:0];
    case (cc[23:8])
      16'hc004: x = s1 & s2;
      16'hc005: x = s1 | s2;
      16'hc006: x = s1 ^ s2;
      16'hc00b: if (lo + sz <= 32) x = (d & ~(m[31:0] << lo)) | ((s1 & m[31:0]) << lo);
      16'hc008, 16'hf00c: x = cc[24] ? {31'h0, bt} : {d[31:1], bt};
      16'hf009: x = d | bm;
      16'hf00a: x = d & ~bm;
      16'hf00b: x = d ^ bm;
      16'hf431, 16'hf909: g = f | bm;
      16'hf432, 16'hf90a: g = f & ~bm;
      16'hf433, 16'hf90b: g = f ^ bm;
      16'hc00c: x = (s2 == 32'h0) ? 32'hffffffff : s1 / s2;
      16'hc00d: x = (s2 == 32'h0) ? s1 : s1 % s2;
      16'hf208: g = (f & ~bm) | ({31'h0, s1[0]} << s2[4:0]);
      default: x = d;
    endcase
    if (cc[24] && cc[23:16] == 8'hc0 && cc[15:8] >= 8'h04 && cc[15:8] <= 8'h06)
      g[11:8] = {x == 32'h0, x[31], 2'b00};
    if (cc[24] && (cc[23:8] == 16'hc008 || cc[23:8] == 16'hf00c))
      g[11:10] = {~bt, 1'b0};
    model = {g, x};
  end
  endfunction

  task st_m(input [1:0] sz, input [31:0] ad, input [31:0] val);
  begin
    if (sz == 2'd2)
    begin
      if (ad[0])
        val = (val & 32'hff) << (ad[1:0] * 8);
      else if (ad[1])
        val = (val & 32'hffff) << 16;
      ad[1:0] = 2'b00;
      {mem[ad + 3], mem[ad + 2], mem[ad + 1], mem[ad]} = val;
    end
    else if (sz == 2'd1)
    begin
      if (ad[0])
        val = (val & 32'hff) << 8;
      ad[0] = 1'b0;
      {mem[ad + 1], mem[ad]} = val[15:0];
    end
    else
      mem[ad] = val[7:0];
  end
  endtask

  function [31:0] ld_m(input [1:0] sz, input [31:0] ad);
  begin
    if (sz == 2'd2)
      ld_m = {mem[{ad[31:2], 2'b11}], mem[{ad[31:2], 2'b10}], mem[{ad[31:2], 2'b01}], mem[{ad[31:2], 2'b00}]};
    else if (sz == 2'd1)
      ld_m = {16'h0, mem[{ad[31:1], 1'b1}], mem[{ad[31:1], 1'b0}]};
    else
      ld_m = {24'h0, mem[ad]};
  end
  endfunction

  task give_verdict;
  begin
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  initial
  begin
    #200000;
    n_errors = n_errors + 1;
    give_verdict;
  end

  initial
  begin
    n_errors = 0;
    check_count = 0;
    seed = 32'h2e7e7bcc;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, `MBD_ADDR_FLAGS, 32'h0);
    chk(q, `MBD_FLAGS_RESET);
    apb(1'b1, `MBD_ADDR_CAPS, 32'hffffffff);
    apb(1'b0, `MBD_ADDR_CAPS, 32'h0);
    chk(q, (`MBD_DSEG_BYTES >> 8) << `MBD_CAPS_SIZE_LSB);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    v = $random(seed);
    apb(1'b1, `MBD_ADDR_SP, v);
    apb(1'b0, `MBD_ADDR_SP, 32'h0);
    chk(q, v & 32'h3fc);
    for (i = 0; i < 18; i = i + 1)
      for (k = 0; k < 4; k = k + 1)
      begin
        key = OPS[i * 16 +: 16];
        s2 = (k == 0) ? 32'h0 : (k == 1) ? 32'h3ff : (k == 2) ? $random(seed) : $random(seed) & 32'hff;
        s1 = $random(seed);
        s1[4:0] = s2[4:0];
        d = $random(seed);
        f = $random(seed);
        c = {8'h00, key, 8'h01} | ((k % 2 == 1 || key[15:1] == 15'h6006) ? 32'h0100_0000 : 32'h0);
        setr(s1, s2, d, f);
        run(c);
        e = model(c);
        apb(1'b0, `MBD_ADDR_DST, 32'h0);
        chk(q, e[31:0]);
        apb(1'b0, `MBD_ADDR_FLAGS, 32'h0);
        chk(q, e[63:32]);
      end
    // operand writes during a divide must be dropped
    setr(32'h0000_1234, 32'h7, 32'h0, 32'h0);
    apb(1'b1, `MBD_ADDR_CTRL, cw(8'hc0, 6'h0c, 2'd0) | 32'h0100_0000);
    apb(1'b1, `MBD_ADDR_SRC1, 32'hffff_0000);
    apb(1'b0, `MBD_ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    wait_idle;
    apb(1'b0, `MBD_ADDR_SRC1, 32'h0);
    chk(q, 32'h0000_1234);
    apb(1'b0, `MBD_ADDR_DST, 32'h0);
    chk(q, 32'h0000_1234 / 7);
    for (k = 0; k < 12; k = k + 1)
    begin
      z = 2'(k % 3);
      b0 = $random(seed) & 32'h3f0;
      v = $random(seed);
      apb(1'b1, `MBD_ADDR_SP, b0);
      setr(b0, 32'h1, v, 32'h0);
      run(cw(k % 2 == 1 ? 8'h38 : 8'h00, k % 2 == 1 ? 6'h1 : 6'h0, 2'd2));
      st_m(2'd2, b0 + 4, v);
      a = b0 + 4 + k / 3;
      v = $random(seed);
      setr(a, 32'h0, v, 32'h0);
      run(cw(8'h00, 6'h0, z));
      st_m(z, a, v);
      run(cw(8'h3c, 6'h8, z));
      apb(1'b0, `MBD_ADDR_RESULT, 32'h0);
      chk(q, ld_m(z, a));
      apb(1'b1, `MBD_ADDR_SRC2, 32'h1);
      run(cw(8'h3a, 6'h0, 2'd2));
      apb(1'b0, `MBD_ADDR_RESULT, 32'h0);
      chk(q, ld_m(2'd2, b0 + 4));
    end
    give_verdict;
  end
endmodule
